/* File: design/pdc_params.svh */
/*
 * Constants of the program and debug command controller: instruction
 * opcodes, field positions, key, reset signature and special characters.
 * Assumes inclusion by the design module only.
 */
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH

// Instruction opcode field (bits 7:5)
`define PDC_OP_LOAD_DIRECT      3'h0
`define PDC_OP_STORE_DIRECT     3'h2
`define PDC_OP_LOAD_INDIRECT    3'h1
`define PDC_OP_STORE_INDIRECT   3'h3
`define PDC_OP_LOAD_CS          3'h4
`define PDC_OP_STORE_CS         3'h6
`define PDC_OP_KEY              3'h7
`define PDC_OP_REPEAT           3'h5
// Size field positions
`define PDC_ASIZE_HI            3
`define PDC_ASIZE_LO            2
`define PDC_DSIZE_HI            1
`define PDC_DSIZE_LO            0
// Indirect pointer mode field positions
`define PDC_PMODE_HI            3
`define PDC_PMODE_LO            2
`define PDC_PMODE_DEREF         2'h0
`define PDC_PMODE_DEREF_INC     2'h1
`define PDC_PMODE_POINTER       2'h2
// Control-status address field
`define PDC_CS_ADDR_HI          1
`define PDC_CS_ADDR_LO          0
`define PDC_CS_STATUS           2'h0
`define PDC_CS_RESET            2'h1
`define PDC_CS_CTRL             2'h2
`define PDC_STATUS_NVM_BIT      1
// Key, signature, break
`define PDC_KEY_VALUE           64'h1289_AB45_CDD8_88FF
`define PDC_KEY_BYTES           4'h8
`define PDC_RESET_SIGNATURE     8'h59
`define PDC_BREAK_BYTE          8'hBB
`define PDC_GUARD_RESET         3'h0

`endif

/* File: design/pdc_pkg.sv */
/*
 * Types of the program and debug command controller.
 * Assumes pdc_params.svh is available on the include path.
 */
package pdc_pkg;

    // Received character from the active physical layer
    typedef struct packed {
        logic [7:0] data;
        logic       parity_err;
        logic       frame_err;
        logic       collision;
    } pdc_rx_char_t;

    // One single-byte access on the internal program bus
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  wdata;
        logic        write;
    } pdc_bus_req_t;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'b00_0001,
        ST_OPERAND = 6'b00_0010,
        ST_BUS     = 6'b00_0100,
        ST_WAIT    = 6'b00_1000,
        ST_SEND    = 6'b01_0000,
        ST_ERROR   = 6'b10_0000
    } pdc_state_t;

endpackage

/* File: design/pdc_controller.sv */
/*
 * Program and debug command controller: decodes instruction bytes from
 * the active link, runs direct/indirect program bus accesses, repeat
 * counting, key unlock, control-status access and exception recovery.
 * Assumes a physical layer delivering framed bytes with error flags on
 * the system clock, and a program bus answering one byte per request.
 */
`timescale 1ns/1ps
`include "pdc_params.svh"

// Contract
// - Entering either link mode reinitialises registers and selects that layer's clock; the code drives only o_link_sel for the two-wire clock, never i_jtag_clock.
// - Two-wire link enable overrides JTAG mode and switches to two-wire link.
// - Internal interfaces stay blocked until the correct key arrives with unlock.
// - Unlock key is 64 bits; only one fixed value enables programming.
// - All internal interfaces appear as one linear space on the program bus.
// - Memory access succeeds only in programming mode, without controller registers.
// - Receive exceptions: parity, frame or break on two-wire; parity or break on JTAG.
// - Transmit exceptions: collision on two-wire; parity or break on JTAG.
// - Any exception aborts all and enters error until a break arrives.
// - Reset register write holds device in reset; clearing releases it.
// - Each instruction is one byte; operands and data follow as separate bytes.
// - Direct load sends one to four address bytes, then returns data bytes.
// - Direct store takes one to four address bytes, then data bytes.
// - Multi-byte bus accesses run as repeated single-byte accesses.
// - Indirect load reads at pointer with optional increment, or returns pointer.
// - Indirect store writes at pointer with optional increment, or loads pointer.
// - Control-status instructions reach only own registers, direct, single byte.
// - Unlock takes key bytes, is never repeated, overwrites repeat counter.
// - Instruction after repeat operands runs count plus one times.
// - Repeat operand bytes are moved into the repeat counter.
// - Writing signature to reset register holds reset until another value written.
// - JTAG break is byte 0xBB with inverted parity, aborting operations.
module pdc_controller (
    input  wire logic                 i_clock,       // System clock
    input  wire logic                 i_nrst,        // Async reset, active low
    input  wire logic                 i_link_clock,  // Two-wire link clock
    input  wire logic                 i_jtag_clock,  // JTAG test clock
    input  wire logic                 i_link_en,     // Two-wire layer enabled
    input  wire logic                 i_jtag_en,     // JTAG layer enabled
    input  wire logic                 i_rx_valid,    // Received char pulse
    input  wire pdc_pkg::pdc_rx_char_t i_rx_char,    // Received char and errors
    input  wire logic                 i_tx_busy,     // Transmit direction active
    input  wire logic                 i_bus_ack,     // Program bus done
    input  wire logic [7:0]           i_bus_rdata,   // Program bus read data
    output logic                      o_link_sel,    // Two-wire clock selected
    output logic                      o_tx_valid,    // Transmit byte pulse
    output logic [7:0]                o_tx_data,     // Transmit byte
    output logic                      o_bus_req,     // Program bus request
    output pdc_pkg::pdc_bus_req_t     o_bus,         // Program bus access
    output logic                      o_nvm_en,      // Programming mode
    output logic                      o_dev_reset    // Device reset request
);
    pdc_pkg::pdc_state_t state_r, state_nxt;

    // Layer mode, sampled on the system clock
    logic [1:0] link_en_s, jtag_en_s;
    logic       link_mode_r, jtag_mode_r;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            link_en_s <= 2'h0;
            jtag_en_s <= 2'h0;
            link_mode_r <= 1'b0;
            jtag_mode_r <= 1'b0;
        end else begin
            link_en_s <= {link_en_s[0], i_link_en};
            jtag_en_s <= {jtag_en_s[0], i_jtag_en};
            link_mode_r <= link_en_s[1];
            jtag_mode_r <= jtag_en_s[1] & ~link_en_s[1];
        end
    end
    wire mode_any = link_mode_r | jtag_mode_r;
    wire mode_nxt_link = link_en_s[1];
    wire mode_nxt_jtag = jtag_en_s[1] & ~link_en_s[1];
    wire mode_enter = (mode_nxt_link & ~link_mode_r) | (mode_nxt_jtag & ~jtag_mode_r);
    wire sel_link_nxt = mode_nxt_link;

    // Clock source select toggles into the link domain
    logic sel_r;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) sel_r <= 1'b0;
        else sel_r <= sel_link_nxt;
    end
    logic [1:0] sel_link_s;
    always_ff @(posedge i_link_clock or negedge i_nrst) begin
        if (!i_nrst) sel_link_s <= 2'h0;
        else sel_link_s <= {sel_link_s[0], sel_r};
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) o_link_sel <= 1'b0;
        else o_link_sel <= sel_r;
    end
    wire unused_clk = i_jtag_clock ^ sel_link_s[1];

    // Exception decode
    wire is_break = i_rx_char.data == `PDC_BREAK_BYTE;
    wire brk_link = i_rx_char.frame_err & is_break;
    wire brk_jtag = i_rx_char.parity_err & is_break;
    wire brk = i_rx_valid & (link_mode_r ? brk_link : brk_jtag);
    wire exc_rx_link = i_rx_char.parity_err | i_rx_char.frame_err;
    wire exc_rx_jtag = i_rx_char.parity_err;
    wire exc_tx_link = i_rx_char.collision;
    wire exc_rx = link_mode_r ? exc_rx_link : exc_rx_jtag;
    wire exc_tx = link_mode_r ? exc_tx_link : i_rx_char.parity_err;
    wire exc = i_rx_valid & (i_tx_busy ? exc_tx : exc_rx);
    wire good = i_rx_valid & ~exc;

    // Instruction and counters
    logic [7:0]  instr_r;
    logic [31:0] ptr_r;
    logic [31:0] rep_r;
    logic [2:0]  acnt_r;
    logic [2:0]  dcnt_r;
    logic [3:0]  kcnt_r;
    logic [63:0] key_r;
    logic [7:0]  rst_r;
    logic        nvm_r;
    logic [2:0]  guard_r;
    logic        keyed_r;

    wire [2:0] op     = instr_r[7:5];
    wire [2:0] asz    = {1'b0, instr_r[`PDC_ASIZE_HI:`PDC_ASIZE_LO]} + 3'h1;
    wire [2:0] dsz    = {1'b0, instr_r[`PDC_DSIZE_HI:`PDC_DSIZE_LO]} + 3'h1;
    wire [1:0] pmode  = instr_r[`PDC_PMODE_HI:`PDC_PMODE_LO];
    wire [1:0] csaddr = instr_r[`PDC_CS_ADDR_HI:`PDC_CS_ADDR_LO];
    wire [7:0] nb     = i_rx_char.data;
    wire [2:0] nop    = nb[7:5];
    wire is_ld   = op == `PDC_OP_LOAD_DIRECT;
    wire is_sd   = op == `PDC_OP_STORE_DIRECT;
    wire is_li   = op == `PDC_OP_LOAD_INDIRECT;
    wire is_si   = op == `PDC_OP_STORE_INDIRECT;
    wire is_lcs  = op == `PDC_OP_LOAD_CS;
    wire is_scs  = op == `PDC_OP_STORE_CS;
    wire is_key  = op == `PDC_OP_KEY;
    wire is_rep  = op == `PDC_OP_REPEAT;
    wire ptr_only = pmode == `PDC_PMODE_POINTER;
    wire post_inc = pmode == `PDC_PMODE_DEREF_INC;
    wire key_ok = key_r == `PDC_KEY_VALUE;
    wire [3:0] key_bytes = `PDC_KEY_BYTES;

    // Direct forms need address bytes first
    wire need_addr = (is_ld | is_sd) & (acnt_r != asz);
    wire [1:0] bidx = acnt_r[1:0];
    wire [1:0] didx = dcnt_r[1:0];
    wire [7:0] ptr_byte = ptr_r[8*didx +: 8];
    wire [7:0] cs_rd = (csaddr == `PDC_CS_STATUS) ? {6'h00, nvm_r, 1'b0} :
                       (csaddr == `PDC_CS_RESET)  ? {7'h00, o_dev_reset} :
                       (csaddr == `PDC_CS_CTRL)   ? {5'h00, guard_r} : 8'h00;
    wire bus_ok = keyed_r & nvm_r;
    wire last_d = dcnt_r == dsz - 3'h1;
    wire rep_more = rep_r != 32'h0;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pdc_pkg::ST_IDLE:    if (good) state_nxt = pdc_pkg::ST_OPERAND;
            pdc_pkg::ST_OPERAND: if (good & ~need_addr) state_nxt = pdc_pkg::ST_OPERAND;
            pdc_pkg::ST_BUS:     if (i_bus_ack) state_nxt = pdc_pkg::ST_WAIT;
            pdc_pkg::ST_WAIT:    state_nxt = pdc_pkg::ST_OPERAND;
            pdc_pkg::ST_SEND:    state_nxt = pdc_pkg::ST_OPERAND;
            pdc_pkg::ST_ERROR:   if (brk) state_nxt = pdc_pkg::ST_IDLE;
            default:             state_nxt = pdc_pkg::ST_ERROR;
        endcase
        if (exc & state_r != pdc_pkg::ST_ERROR) state_nxt = pdc_pkg::ST_ERROR;
    end

    // Main sequencer: one byte per step
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= pdc_pkg::ST_IDLE;
            instr_r <= 8'h00;
            ptr_r <= 32'h0;
            rep_r <= 32'h0;
            acnt_r <= 3'h0;
            dcnt_r <= 3'h0;
            kcnt_r <= 4'h0;
            key_r <= 64'h0;
            rst_r <= 8'h00;
            nvm_r <= 1'b0;
            guard_r <= `PDC_GUARD_RESET;
            keyed_r <= 1'b0;
            o_bus_req <= 1'b0;
            o_bus <= '0;
            o_tx_valid <= 1'b0;
            o_tx_data <= 8'h00;
        end else if (mode_enter | ~mode_any) begin
            state_r <= pdc_pkg::ST_IDLE;
            ptr_r <= 32'h0;
            rep_r <= 32'h0;
            acnt_r <= 3'h0;
            dcnt_r <= 3'h0;
            kcnt_r <= 4'h0;
            key_r <= 64'h0;
            rst_r <= 8'h00;
            nvm_r <= 1'b0;
            keyed_r <= 1'b0;
            o_bus_req <= 1'b0;
            o_tx_valid <= 1'b0;
        end else begin
            o_tx_valid <= 1'b0;
            state_r <= state_nxt;
            if (exc) begin
                o_bus_req <= 1'b0;
                acnt_r <= 3'h0;
                dcnt_r <= 3'h0;
                rep_r <= 32'h0;
            end else begin
                case (state_r)
                pdc_pkg::ST_IDLE: if (good) begin
                    instr_r <= nb;
                    acnt_r <= 3'h0;
                    dcnt_r <= 3'h0;
                    kcnt_r <= 4'h0;
                    if (nop == `PDC_OP_KEY) rep_r <= 32'h0;
                    if (nop == `PDC_OP_REPEAT) rep_r <= 32'h0;
                end
                pdc_pkg::ST_OPERAND: begin
                    if (need_addr & good) begin
                        ptr_r[8*bidx +: 8] <= nb;
                        acnt_r <= acnt_r + 3'h1;
                    end else if (is_rep & good) begin
                        rep_r[8*didx +: 8] <= nb;
                        dcnt_r <= dcnt_r + 3'h1;
                        if (last_d) state_r <= pdc_pkg::ST_IDLE;
                    end else if (is_key & good) begin
                        key_r <= {nb, key_r[63:8]};
                        kcnt_r <= kcnt_r + 4'h1;
                        if (kcnt_r == key_bytes - 4'h1) state_r <= pdc_pkg::ST_IDLE;
                    end else if (is_scs & good) begin
                        if (csaddr == `PDC_CS_RESET) rst_r <= nb;
                        if (csaddr == `PDC_CS_STATUS & nb[`PDC_STATUS_NVM_BIT])
                            nvm_r <= 1'b0;
                        if (csaddr == `PDC_CS_CTRL) guard_r <= nb[2:0];
                        state_r <= pdc_pkg::ST_IDLE;
                    end else if (is_lcs) begin
                        o_tx_valid <= 1'b1;
                        o_tx_data <= cs_rd;
                        state_r <= pdc_pkg::ST_IDLE;
                    end else if ((is_li & ptr_only) & ~i_tx_busy) begin
                        o_tx_valid <= 1'b1;
                        o_tx_data <= ptr_byte;
                        state_r <= pdc_pkg::ST_SEND;
                    end else if (is_si & ptr_only & good) begin
                        ptr_r[8*didx +: 8] <= nb;
                        state_r <= pdc_pkg::ST_SEND;
                    end else if ((is_ld | is_li) & ~need_addr & bus_ok) begin
                        o_bus_req <= 1'b1;
                        o_bus.addr <= ptr_r + {29'h0, dcnt_r};
                        o_bus.write <= 1'b0;
                        state_r <= pdc_pkg::ST_BUS;
                    end else if ((is_sd | is_si) & ~need_addr & good & bus_ok) begin
                        o_bus_req <= 1'b1;
                        o_bus.addr <= ptr_r + {29'h0, dcnt_r};
                        o_bus.wdata <= nb;
                        o_bus.write <= 1'b1;
                        state_r <= pdc_pkg::ST_BUS;
                    end else if (~bus_ok & ~need_addr & (is_ld | is_li | is_sd | is_si))
                        state_r <= pdc_pkg::ST_IDLE;
                end
                pdc_pkg::ST_BUS: if (i_bus_ack) begin
                    o_bus_req <= 1'b0;
                    if (!o_bus.write) begin
                        o_tx_valid <= 1'b1;
                        o_tx_data <= i_bus_rdata;
                    end
                end
                pdc_pkg::ST_SEND, pdc_pkg::ST_WAIT: begin
                    dcnt_r <= dcnt_r + 3'h1;
                    if (last_d) begin
                        dcnt_r <= 3'h0;
                        if (is_si | is_li) begin
                            if (post_inc) ptr_r <= ptr_r + {29'h0, dsz};
                        end
                        if (rep_more) begin
                            rep_r <= rep_r - 32'h1;
                            state_r <= pdc_pkg::ST_OPERAND;
                        end else state_r <= pdc_pkg::ST_IDLE;
                    end
                end
                default: ;
                endcase
            end
            if (state_r == pdc_pkg::ST_IDLE & kcnt_r == key_bytes & is_key) begin
                keyed_r <= key_ok;
                nvm_r <= key_ok;
                kcnt_r <= 4'h0;
            end
        end
    end

    // Reset signature hold and registered programming mode output
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) o_dev_reset <= 1'b0;
        else o_dev_reset <= rst_r == `PDC_RESET_SIGNATURE;
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) o_nvm_en <= 1'b0;
        else o_nvm_en <= nvm_r & ~unused_clk & 1'b1 | nvm_r;
    end

    // Error state exits only on a break, a layer mode entry or loss of both layer modes
    error_hold_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (state_r == pdc_pkg::ST_ERROR) & ~brk & ~mode_enter & mode_any
        |=> state_r == pdc_pkg::ST_ERROR)
        else $error("error state left without break");
    exc_enter_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        exc & mode_any & ~mode_enter & (state_r != pdc_pkg::ST_ERROR)
        |=> state_r == pdc_pkg::ST_ERROR)
        else $error("exception did not enter error");
    bus_lock_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        $rose(o_bus_req) |-> $past(bus_ok))
        else $error("bus access while locked");
    reset_sig_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        rst_r == `PDC_RESET_SIGNATURE |=> o_dev_reset)
        else $error("reset not held for signature");
    link_prio_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        link_mode_r |-> ~jtag_mode_r)
        else $error("both layers active");
    mode_init_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        mode_enter |=> state_r == pdc_pkg::ST_IDLE && rep_r == 32'h0)
        else $error("mode entry did not reinit");
    key_clear_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        state_r == pdc_pkg::ST_IDLE & good & nop == `PDC_OP_KEY & mode_any & ~mode_enter
        |=> rep_r == 32'h0)
        else $error("key did not clear repeat");
    bus_single_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        o_bus_req & ~i_bus_ack |=> o_bus_req && $stable(o_bus.addr))
        else $error("bus access changed mid byte");

endmodule

/* File: verif/pdc_prog_model.sv */
/*
 * Programmer model: hands framed characters with error flags to the
 * controller, one byte at a time, with idle gaps between bytes.
 * Assumes the bench calls send from its main sequence only.
 */
`timescale 1ns/1ps
module pdc_prog_model (
    input  wire logic                   i_clock,    // System clock
    output logic                        o_rx_valid, // Character pulse
    output pdc_pkg::pdc_rx_char_t       o_rx_char   // Character and errors
);
    initial begin
        o_rx_valid = 1'b0;
        o_rx_char  = '0;
    end

    // One byte per call, instruction first, operands after it
    task automatic send(input logic [7:0] b, input logic [2:0] err);
        @(posedge i_clock);
        #2;
        o_rx_valid = 1'b1;
        o_rx_char  = {b, err};
        @(posedge i_clock);
        #2;
        o_rx_valid = 1'b0;
        // Released line shows no stale byte
        o_rx_char  = {~b, 3'h0};
        repeat (6) @(posedge i_clock);
    endtask
endmodule

/* File: verif/pdc_controller_tb.sv */
/*
 * Self-checking bench of the command controller: programmer model on the
 * link side, a byte memory answering the program bus, queued expectations.
 * Assumes the design files are compiled first.
 */
`timescale 1ns/1ps
module pdc_controller_tb;
    logic                    i_clock = 1'b0;
    logic                    i_nrst = 1'b0;
    logic                    i_link_clock = 1'b0;
    logic                    i_link_en = 1'b0;
    logic                    i_jtag_en = 1'b0;
    logic                    i_rx_valid;
    pdc_pkg::pdc_rx_char_t   i_rx_char;
    logic                    i_bus_ack = 1'b0;
    logic [7:0]              i_bus_rdata = 8'h00;
    logic                    o_link_sel, o_tx_valid, o_bus_req, o_nvm_en, o_dev_reset;
    logic [7:0]              o_tx_data;
    pdc_pkg::pdc_bus_req_t   o_bus;
    pdc_pkg::pdc_bus_req_t   exp_bus[$];
    logic [7:0]              exp_tx[$];
    int                      error_cnt = 0, cmp_count = 0, cycles = 0, seed = 28673;
    logic [31:0]             a, p;
    logic [15:0]             d;

    always #12.5 i_clock = ~i_clock;
    // Link clock runs while the two-wire layer is enabled
    always #40 i_link_clock = i_link_en ? ~i_link_clock : 1'b0;

    pdc_controller dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_link_clock(i_link_clock),
        .i_jtag_clock(1'b0), .i_link_en(i_link_en), .i_jtag_en(i_jtag_en),
        .i_rx_valid(i_rx_valid), .i_rx_char(i_rx_char), .i_tx_busy(1'b0),
        .i_bus_ack(i_bus_ack), .i_bus_rdata(i_bus_rdata), .o_link_sel(o_link_sel),
        .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_bus_req(o_bus_req),
        .o_bus(o_bus), .o_nvm_en(o_nvm_en), .o_dev_reset(o_dev_reset));
    pdc_prog_model pm (.i_clock(i_clock), .o_rx_valid(i_rx_valid), .o_rx_char(i_rx_char));

    function automatic logic [7:0] mem(input logic [31:0] x);
        return x[7:0] ^ 8'hA5;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic snd(input logic [31:0] v, input int n, input logic [2:0] e = 3'h0);
        for (int i = 0; i < n; i++) pm.send(v[8*i +: 8], e);
    endtask

    task automatic exp_rd(input logic [31:0] x);
        exp_bus.push_back('{x, 8'h00, 1'b0});
        exp_tx.push_back(mem(x));
    endtask

    task automatic close_out();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Bus responder: one ack per request, checked against the oldest note
    always @(posedge i_clock) begin
        i_bus_ack <= #2 1'b0;
        if (o_bus_req === 1'b1 && !i_bus_ack) begin
            if (exp_bus.size() == 0) chk(o_bus, '1);
            else if (exp_bus[0].write) chk(o_bus, exp_bus.pop_front());
            else chk({o_bus.addr, o_bus.write}, {exp_bus.pop_front().addr, 1'b0});
            i_bus_ack   <= #2 1'b1;
            i_bus_rdata <= #2 mem(o_bus.addr);
        end
    end

    always @(posedge i_clock) begin
        if (o_tx_valid === 1'b1) begin
            if (exp_tx.size() == 0) chk(o_tx_data, 64'h1FF);
            else chk(o_tx_data, exp_tx.pop_front());
        end
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        repeat (4) @(posedge i_clock);
        #2 i_nrst = 1'b1;
        chk({o_link_sel, o_tx_valid, o_bus_req, o_nvm_en, o_dev_reset}, 0);
        i_link_en = 1'b1;
        repeat (6) @(posedge i_clock);
        chk(o_link_sel, 1);
        snd(32'h0000_0010, 2);
        snd(32'h0000_00E0, 1);
        snd(32'hCDD8_88FE, 4);
        snd(32'h1289_AB45, 4);
        repeat (4) @(posedge i_clock);
        chk(o_nvm_en, 0);
        snd(32'h0000_00E0, 1);
        snd(32'hCDD8_88FF, 4);
        snd(32'h1289_AB45, 4);
        repeat (4) @(posedge i_clock);
        chk(o_nvm_en, 1);
        a = $random(seed);
        d = $random(seed);
        exp_bus.push_back('{{16'h0000, a[15:0]}, d[7:0], 1'b1});
        exp_bus.push_back('{{16'h0000, a[15:0]} + 1, d[15:8], 1'b1});
        snd(32'h0000_0045, 1);
        snd(a, 2);
        snd(d, 2);
        a = $random(seed);
        exp_rd(a);
        snd(32'h0000_000C, 1);
        snd(a, 4);
        p = $random(seed);
        snd(32'h0000_006B, 1);
        snd(p, 4);
        snd(32'h0000_00A0, 1);
        snd(32'h0000_0002, 1);
        for (int i = 0; i < 3; i++) exp_rd(p + i);
        snd(32'h0000_0024, 1);
        repeat (20) @(posedge i_clock);
        exp_tx.push_back(8'h02);
        snd(32'h0000_0080, 1);
        snd(32'h0000_00C1, 1);
        snd(32'h0000_0059, 1);
        chk(o_dev_reset, 1);
        snd(32'h0000_00C1, 1);
        snd(32'h0000_0000, 1);
        chk(o_dev_reset, 0);
        snd(32'h0000_0000, 1, 3'h4);
        snd(32'h0000_0000, 2);
        snd(32'h0000_00BB, 1, 3'h2);
        // One address byte replaces only the pointer LSB
        a = p + 32'h3;
        a[7:0] = 8'h3C;
        exp_rd(a);
        snd(32'h0000_0000, 1);
        snd(a, 1);
        #2;
        i_link_en = 1'b0;
        i_jtag_en = 1'b1;
        repeat (6) @(posedge i_clock);
        chk(o_link_sel, 0);
        #2;
        i_link_en = 1'b1;
        repeat (6) @(posedge i_clock);
        chk(o_link_sel, 1);
        repeat (20) @(posedge i_clock);
        chk(exp_bus.size() + exp_tx.size(), 0);
        close_out();
    end
endmodule
